// ### scic_pkg.sv
/*
  Constants, register map and state encoding for the safe current input coder.
  Assumes one 250 MHz clock; all times below are in milliseconds unless named otherwise.
*/
package scic_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_HZ       = 250_000_000;
  localparam int TICK_MS      = 1;
  localparam int CLKS_PER_MS  = CLK_HZ / 1000 * TICK_MS;
  localparam int BASE_MS      = 20;
  localparam int CHAN_MS_50HZ = 25;
  localparam int CHAN_MS_60HZ = 22;
  localparam int ACK_MS       = 20;
  localparam int NCH          = 4;

  // ************************************************************
  // analog coding
  // ************************************************************
  localparam logic signed [19:0] RAW_4MA      = 20'sh06C00;
  localparam logic signed [19:0] DIV_0_20     = 20'sh00005;
  localparam logic signed [19:0] CODE_OVF_MIN = 20'sh07F00;
  localparam logic signed [19:0] CODE_WB_020  = 20'sh00265;
  localparam logic signed [19:0] CODE_WB_420  = 20'shFFD4C;
  localparam logic signed [19:0] CODE_UNF_MAX = 20'shFE7FF;
  localparam logic [15:0]        OUT_OVF      = 16'h7FFF;
  localparam logic [15:0]        OUT_UNF      = 16'h8000;
  localparam logic [15:0]        OUT_ZERO     = 16'h0000;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_DISC_TIME  = 12'h004;
  localparam logic [11:0] REG_DISC_TOL   = 12'h008;
  localparam logic [11:0] REG_STATUS     = 12'h00C;
  localparam logic [11:0] REG_MASK       = 12'h010;
  localparam logic [11:0] REG_CYCLE      = 12'h014;
  localparam logic [11:0] REG_VALUE_BASE = 12'h020;

  localparam int CTRL_EN_LSB   = 0;
  localparam int CTRL_F60_BIT  = 4;
  localparam int CTRL_R420_LSB = 5;
  localparam int CTRL_WBD_BIT  = 9;
  localparam int CTRL_FAM_BIT  = 10;
  localparam int CTRL_SMO_LSB  = 11;
  localparam int CTRL_1OO2_LSB = 13;
  localparam int CTRL_W        = 15;

  localparam int ST_WB_LSB   = 0;
  localparam int ST_OU_LSB   = 4;
  localparam int ST_CF_LSB   = 8;
  localparam int ST_DISC_LSB = 12;
  localparam int ST_CYC_BIT  = 14;
  localparam int ST_W        = 15;

  localparam logic [14:0] CTRL_RST      = 15'h000F;
  localparam logic [15:0] DISC_TIME_RST = 16'h0064;
  localparam logic [15:0] DISC_TOL_RST  = 16'h0100;
  localparam logic [14:0] MASK_RST      = 15'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // scheduler states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_BASE = 3'h1,
    ST_SLOT = 3'h2,
    ST_END  = 3'h4
  } scic_state_t;

endpackage : scic_pkg

// ### scic_coder.sv
/*
  Converts one smoothed raw sample into its 16-bit signed output code.
  Raw unit is 20 mA / 138240, so 4 mA is 27648 raw; input is on the core clock.
*/
`timescale 1ns/1ns
module scic_coder (
  // sample and setup
  input  wire logic signed [19:0] raw,
  input  wire logic               range420,
  input  wire logic               wb_diag,
  input  wire logic               family_zero,
  // result
  output logic [15:0]             code,
  output logic                    wire_break,
  output logic                    over_flow,
  output logic                    under_flow
);

  // ************************************************************
  // scaling and classification
  // ************************************************************
  wire logic signed [19:0] diff420 = raw - scic_pkg::RAW_4MA;
  wire logic signed [19:0] scaled  = range420 ? (diff420 >>> 2) : (raw / scic_pkg::DIV_0_20);
  wire logic [15:0]        wb_out  = family_zero ? scic_pkg::OUT_ZERO : scic_pkg::OUT_OVF;

  assign over_flow  = scaled >= scic_pkg::CODE_OVF_MIN;
  assign wire_break = wb_diag && (range420 ? (scaled <= scic_pkg::CODE_WB_420)
                                           : (scaled <= scic_pkg::CODE_WB_020));
  assign under_flow = range420 && !wire_break && (scaled <= scic_pkg::CODE_UNF_MAX);

  // clamp instead of wrap; 16-bit two's complement result
  assign code = wire_break               ? wb_out :
                over_flow                ? scic_pkg::OUT_OVF :
                under_flow               ? scic_pkg::OUT_UNF :
                (!range420 && scaled < 0) ? scic_pkg::OUT_ZERO :
                scaled[15:0];

endmodule : scic_coder

// ### scic_core.sv
/*
  Safe current input coder: schedules four current channels over a converter,
  smooths and codes each result, evaluates faults and serves an AXI4-Lite slave.
  Assumes the converter runs on CLK and answers each start with one done pulse.
*/
// Design decisions made here: the address map and register access over AXI4-Lite.
// Contract
// - cycle equals 20 ms plus channels times slot
// - slot 25 ms at 50 Hz, 22 at 60
// - each enabled channel converted once, others skipped
// - controller requests acknowledged within 20 ms
// - smoothing sets response, at most twice typical
// - discrepancy adds discrepancy time plus cycles
// - channel fault reacts within one or two cycles
// - values are 16-bit two's complement
// - 0-20 mA codes, overrange, overflow, wire break
// - 4-20 mA codes, underrange and underflow
// - below 3.6 mA reports wire break; 0-20 mA range reports it only at code 0x265 and below
// - wire break substitutes 7FFF or zero
// - two-channel uses discrepancy, single uses fault
`timescale 1ns/1ns
module scic_core #(
  parameter int CLKS_PER_MS = scic_pkg::CLKS_PER_MS
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // axi4-lite write address and data
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // converter
  output logic             ADC_START,
  output logic [1:0]       ADC_CHAN,
  input  wire logic        ADC_DONE,
  input  wire logic [17:0] ADC_RESULT,
  input  wire logic        ADC_FAULT,
  // interrupt
  output logic             IRQ
);

  // ************************************************************
  // register state
  // ************************************************************
  logic [14:0]        ctrl_q;
  logic [15:0]        disc_time_q;
  logic [15:0]        disc_tol_q;
  logic [14:0]        status_q;
  logic [14:0]        mask_q;
  logic               aw_have_q;
  logic               w_have_q;
  logic [11:0]        awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               irq_q;

  wire logic [3:0]    en        = ctrl_q[scic_pkg::CTRL_EN_LSB +: 4];
  wire logic          f60       = ctrl_q[scic_pkg::CTRL_F60_BIT];
  wire logic [3:0]    r420      = ctrl_q[scic_pkg::CTRL_R420_LSB +: 4];
  wire logic          wb_diag   = ctrl_q[scic_pkg::CTRL_WBD_BIT];
  wire logic          fam_zero  = ctrl_q[scic_pkg::CTRL_FAM_BIT];
  wire logic [1:0]    smooth    = ctrl_q[scic_pkg::CTRL_SMO_LSB +: 2];
  wire logic [1:0]    pair_1oo2 = ctrl_q[scic_pkg::CTRL_1OO2_LSB +: 2];

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  wire logic          aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire logic          w_take  = S_AXI_WVALID && S_AXI_WREADY;
  wire logic          wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;
  wire logic [31:0]   wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire logic [31:0]   wbits   = wdata_q & wmask;
  wire logic          wr_ctrl = wr_fire && (awaddr_q == scic_pkg::REG_CTRL);
  wire logic          wr_dtim = wr_fire && (awaddr_q == scic_pkg::REG_DISC_TIME);
  wire logic          wr_dtol = wr_fire && (awaddr_q == scic_pkg::REG_DISC_TOL);
  wire logic          wr_stat = wr_fire && (awaddr_q == scic_pkg::REG_STATUS);
  wire logic          wr_mask = wr_fire && (awaddr_q == scic_pkg::REG_MASK);
  wire logic          wr_hit  = wr_ctrl || wr_dtim || wr_dtol || wr_stat || wr_mask;

  assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_have_q && !S_AXI_BVALID;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {S_AXI_AWADDR[11:2], 2'h0};
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= scic_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? scic_pkg::RESP_OKAY : scic_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q      <= scic_pkg::CTRL_RST;
      disc_time_q <= scic_pkg::DISC_TIME_RST;
      disc_tol_q  <= scic_pkg::DISC_TOL_RST;
      mask_q      <= scic_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= (ctrl_q & ~wmask[14:0]) | wbits[14:0];
      if (wr_dtim) disc_time_q <= (disc_time_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_dtol) disc_tol_q <= (disc_tol_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_mask) mask_q <= (mask_q & ~wmask[14:0]) | wbits[14:0];
    end
  end

  // ************************************************************
  // conversion scheduler
  // ************************************************************
  scic_pkg::scic_state_t state_q;
  logic [17:0]        ms_div_q;
  logic [7:0]         ms_q;
  logic [1:0]         ch_q;
  logic               got_q;
  logic               fault_q;
  logic [17:0]        res_q;
  logic               nxt_found;
  logic [1:0]         nxt_ch;
  logic [2:0]         n_en;

  wire logic [7:0]    slot_ms   = f60 ? 8'(scic_pkg::CHAN_MS_60HZ) : 8'(scic_pkg::CHAN_MS_50HZ);
  wire logic [7:0]    phase_m1  = (state_q == scic_pkg::ST_BASE) ? 8'(scic_pkg::BASE_MS - 1) : slot_ms - 8'h01;
  wire logic          tick      = ms_div_q == 18'(CLKS_PER_MS - 1);
  wire logic          phase_end = tick && (ms_q >= phase_m1) && (state_q != scic_pkg::ST_END);
  wire logic          slot_done = phase_end && (state_q == scic_pkg::ST_SLOT);
  wire logic          cyc_end   = state_q == scic_pkg::ST_END;

  // next enabled channel above the current one, or from zero after the base phase
  always_comb begin
    nxt_found = 1'b0;
    nxt_ch    = 2'h0;
    for (int i = scic_pkg::NCH - 1; i >= 0; i--) begin
      if (en[i] && ((state_q == scic_pkg::ST_BASE) || (2'(i) > ch_q))) begin
        nxt_found = 1'b1;
        nxt_ch    = 2'(i);
      end
    end
  end

  always_comb begin
    n_en = 3'h0;
    for (int i = 0; i < scic_pkg::NCH; i++) begin
      n_en = n_en + 3'(en[i]);
    end
  end

  wire logic [15:0]   cycle_ms = 16'(scic_pkg::BASE_MS) + 16'(n_en) * 16'(slot_ms);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_q   <= scic_pkg::ST_BASE;
      ms_div_q  <= '0;
      ms_q      <= '0;
      ch_q      <= '0;
      ADC_START <= 1'b0;
    end else begin
      ADC_START <= 1'b0;
      ms_div_q  <= (tick || phase_end || cyc_end) ? 18'h00000 : ms_div_q + 18'h00001;
      if (phase_end || cyc_end) ms_q <= 8'h00;
      else if (tick) ms_q <= ms_q + 8'h01;
      unique case (state_q)
        scic_pkg::ST_BASE, scic_pkg::ST_SLOT: begin
          if (phase_end && nxt_found) begin
            state_q   <= scic_pkg::ST_SLOT;
            ch_q      <= nxt_ch;
            ADC_START <= 1'b1;
          end else if (phase_end) begin
            state_q <= scic_pkg::ST_END;
          end
        end
        scic_pkg::ST_END: begin
          state_q <= scic_pkg::ST_BASE;
        end
        default: begin
          state_q <= scic_pkg::ST_BASE;
        end
      endcase
    end
  end

  assign ADC_CHAN = ch_q;

  // a slot without a done pulse counts as a channel fault
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      got_q   <= 1'b0;
      fault_q <= 1'b0;
      res_q   <= '0;
    end else if (ADC_START) begin
      got_q   <= 1'b0;
      fault_q <= 1'b0;
    end else if (ADC_DONE && (state_q == scic_pkg::ST_SLOT) && !got_q) begin
      got_q   <= 1'b1;
      fault_q <= ADC_FAULT;
      res_q   <= ADC_RESULT;
    end
  end

  // ************************************************************
  // smoothing and coding of the slot just finished
  // ************************************************************
  logic signed [19:0] filt_q      [scic_pkg::NCH];
  logic [15:0]        pend_code_q [scic_pkg::NCH];
  logic [2:0]         pend_flag_q [scic_pkg::NCH];
  logic [15:0]        value_q     [scic_pkg::NCH];
  logic [2:0]         vflag_q     [scic_pkg::NCH];
  logic               disc_seen_q [2];
  logic               disc_fault_q[2];
  logic [15:0]        disc_ms_q   [2];
  logic [15:0]        coded;
  logic               c_wb;
  logic               c_ovf;
  logic               c_unf;

  wire logic signed [19:0] filt_cur  = filt_q[ch_q];
  wire logic signed [19:0] sample_in = got_q ? $signed({2'h0, res_q}) : filt_cur;
  wire logic signed [19:0] filt_next = filt_cur + ((sample_in - filt_cur) >>> smooth);
  wire logic               cf_now    = fault_q || !got_q;

  scic_coder u_coder (
    .raw         (filt_next),
    .range420    (r420[ch_q]),
    .wb_diag     (wb_diag),
    .family_zero (fam_zero),
    .code        (coded),
    .wire_break  (c_wb),
    .over_flow   (c_ovf),
    .under_flow  (c_unf)
  );

  wire [3:0]          wb_ev;
  wire [3:0]          ou_ev;
  wire [3:0]          cf_ev;
  wire [1:0]          disc_ev;

  for (genvar c = 0; c < scic_pkg::NCH; c++) begin : g_ch
    wire logic this_slot = slot_done && (ch_q == 2'(c));
    wire logic passive   = pair_1oo2[c / 2] ? disc_fault_q[c / 2] : pend_flag_q[c][2];

    always_ff @(posedge CLK) begin
      if (!RESETN) begin
        filt_q[c]      <= '0;
        pend_code_q[c] <= '0;
        pend_flag_q[c] <= '0;
        value_q[c]     <= '0;
        vflag_q[c]     <= '0;
      end else begin
        if (this_slot) begin
          filt_q[c]      <= filt_next;
          pend_code_q[c] <= coded;
          pend_flag_q[c] <= {cf_now, c_ovf || c_unf, c_wb};
        end
        if (cyc_end) begin
          value_q[c] <= (!en[c] || passive) ? scic_pkg::OUT_ZERO : pend_code_q[c];
          vflag_q[c] <= en[c] ? pend_flag_q[c] : 3'h0;
        end
      end
    end

    assign wb_ev[c] = cyc_end && en[c] && pend_flag_q[c][0];
    assign ou_ev[c] = cyc_end && en[c] && pend_flag_q[c][1];
    assign cf_ev[c] = cyc_end && en[c] && pend_flag_q[c][2];
  end

  // ************************************************************
  // two-channel discrepancy evaluation
  // ************************************************************
  for (genvar p = 0; p < 2; p++) begin : g_pair
    wire logic [15:0]        ca      = pend_code_q[2 * p];
    wire logic [15:0]        cb      = pend_code_q[2 * p + 1];
    wire logic signed [16:0] dd      = $signed({ca[15], ca}) - $signed({cb[15], cb});
    wire logic [16:0]        dd_abs  = dd[16] ? 17'(-dd) : 17'(dd);
    wire logic               pair_on = pair_1oo2[p] && en[2 * p] && en[2 * p + 1];
    wire logic               over    = pair_on && (dd_abs > {1'b0, disc_tol_q});

    always_ff @(posedge CLK) begin
      if (!RESETN) begin
        disc_seen_q[p]  <= 1'b0;
        disc_fault_q[p] <= 1'b0;
        disc_ms_q[p]    <= '0;
      end else begin
        if (cyc_end) begin
          disc_seen_q[p] <= over;
          if (!over) disc_fault_q[p] <= 1'b0;
          else if (disc_seen_q[p] && (disc_ms_q[p] >= disc_time_q)) disc_fault_q[p] <= 1'b1;
        end
        if (!disc_seen_q[p] || (cyc_end && !over)) disc_ms_q[p] <= 16'h0000;
        else if (tick && (disc_ms_q[p] != 16'hFFFF)) disc_ms_q[p] <= disc_ms_q[p] + 16'h0001;
      end
    end

    assign disc_ev[p] = cyc_end && over && disc_seen_q[p] && (disc_ms_q[p] >= disc_time_q);
  end

  // ************************************************************
  // status, mask and interrupt
  // ************************************************************
  wire logic [14:0]   st_set = {cyc_end, disc_ev, cf_ev, ou_ev, wb_ev};
  wire logic [14:0]   st_clr = wr_stat ? wbits[14:0] : 15'h0000;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
      irq_q    <= |(status_q & mask_q);
    end
  end

  assign IRQ = irq_q;

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  wire logic          rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic [11:0]   raddr   = {S_AXI_ARADDR[11:2], 2'h0};
  wire logic          rd_val  = raddr[11:4] == scic_pkg::REG_VALUE_BASE[11:4];
  wire logic [1:0]    rd_idx  = raddr[3:2];
  wire logic          rd_ctrl = raddr == scic_pkg::REG_CTRL;
  wire logic          rd_dtim = raddr == scic_pkg::REG_DISC_TIME;
  wire logic          rd_dtol = raddr == scic_pkg::REG_DISC_TOL;
  wire logic          rd_stat = raddr == scic_pkg::REG_STATUS;
  wire logic          rd_mask = raddr == scic_pkg::REG_MASK;
  wire logic          rd_cyc  = raddr == scic_pkg::REG_CYCLE;
  wire logic          rd_hit  = rd_val || rd_ctrl || rd_dtim || rd_dtol || rd_stat || rd_mask || rd_cyc;
  wire logic [31:0]   rd_mux  = rd_val  ? {13'h0000, vflag_q[rd_idx], value_q[rd_idx]} :
                                rd_ctrl ? {17'h00000, ctrl_q} :
                                rd_dtim ? {16'h0000, disc_time_q} :
                                rd_dtol ? {16'h0000, disc_tol_q} :
                                rd_stat ? {17'h00000, status_q} :
                                rd_mask ? {17'h00000, mask_q} :
                                rd_cyc  ? {16'h0000, cycle_ms} : 32'h00000000;

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= scic_pkg::RESP_OKAY;
    end else if (rd_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_mux;
      S_AXI_RRESP  <= rd_hit ? scic_pkg::RESP_OKAY : scic_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule : scic_core

// ### scic_core_checker.sv
/*
  Concurrent checks on the bus and converter ports of scic_core.
  Assumes one clock CLK and the synchronous active-low reset RESETN.
*/
`timescale 1ns/1ns
module scic_core_checker #(
  parameter int CLKS_PER_MS = 10
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // converter
  input wire logic        ADC_START,
  input wire logic [1:0]  ADC_CHAN
);
  localparam int MIN_GAP = scic_pkg::CHAN_MS_60HZ * CLKS_PER_MS - 1;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic [31:0] gap_q;
  logic        seen_q;
  // cycles since the last converter start
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      gap_q  <= 32'h00000000;
      seen_q <= 1'b0;
    end else if (ADC_START) begin
      gap_q  <= 32'h00000000;
      seen_q <= 1'b1;
    end else begin
      gap_q  <= gap_q + 32'h00000001;
    end
  end
  sequence s_pulse; ADC_START ##1 !ADC_START; endsequence
  sequence s_rd_take; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  sequence s_wr_take; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  slot_gap_a: assert property (ADC_START && seen_q |-> gap_q >= MIN_GAP)
    else $error("converter start too soon");
  start_pulse_a: assert property (ADC_START |-> s_pulse)
    else $error("converter start longer than one cycle");
  chan_hold_a: assert property (ADC_START |=> $stable(ADC_CHAN) [*8])
    else $error("channel moved inside slot");
  read_answer_a: assert property (s_rd_take |=> S_AXI_RVALID)
    else $error("read not answered");
  read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer not held");
  read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  write_answer_a: assert property (s_wr_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write not answered");
  write_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer not held");
  write_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
endmodule : scic_core_checker

bind scic_core scic_core_checker #(.CLKS_PER_MS(CLKS_PER_MS)) u_chk (.*);

// ### scic_adc_model.sv
/*
  Converter model: answers each start with one done pulse after a set delay.
  Assumes start is a one-cycle pulse on clk.
*/
`timescale 1ns/1ns
module scic_adc_model (
  // control
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [17:0] res,
  input  wire logic        flt,
  input  wire logic [7:0]  dly,
  // answer
  output logic             done = 1'b0,
  output logic [17:0]      result = 18'h00000,
  output logic             fault = 1'b0
);
  logic [7:0] cnt_q = 8'h00;
  logic       busy_q = 1'b0;
  // idle lines toggle so stale data never looks valid
  always @(posedge clk) begin
    done   <= 1'b0;
    result <= ~result;
    fault  <= ~fault;
    if (start) begin
      busy_q <= 1'b1;
      cnt_q  <= dly;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q <= 1'b0;
      done   <= 1'b1;
      result <= res;
      fault  <= flt;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 8'h01;
    end
  end
endmodule : scic_adc_model

// ### safe_current_input_coder_test.sv
/*
  Self-checking bench for scic_core driving the bus and a converter model.
  Assumes scic_pkg is compiled first; the ms tick is cut to 10 clocks.
*/
`timescale 1ns/1ns
module safe_current_input_coder_test;
  localparam int K = 10;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000, rd, d;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, flt = 1'b0;
  logic [17:0] res = 18'h00000, rs;
  logic [7:0]  dly = 8'h00;
  logic        awr, wr, bv, arr, rv, st, dn, ft, irq;
  logic [1:0]  br, rr, ch, r;
  logic [1:0]  chq[$];
  logic [45:0] rows[13] = '{{12'h001, 18'h21C00, 16'h6C00}, {12'h001, 18'h27AFB, 16'h7EFF},
    {12'h001, 18'h27B00, 16'h7FFF}, {12'h001, 18'h3FFFF, 16'h7FFF}, {12'h201, 18'h00BF9, 16'h7FFF},
    {12'h601, 18'h00BF9, 16'h0000}, {12'h201, 18'h00BFE, 16'h0266}, {12'h021, 18'h06C00, 16'h0000},
    {12'h021, 18'h00BFC, 16'h8000}, {12'h021, 18'h00C00, 16'hE800}, {12'h221, 18'h06130, 16'h7FFF},
    {12'h221, 18'h06134, 16'hFD4D}, {12'h801, 18'h21C00, 16'h55DC}};
  int err_count = 0, total_checks = 0, cyc = 0, per = 0, last = 0;
  always #2 CLK = ~CLK;
  scic_core #(.CLKS_PER_MS(K)) u_dut (.CLK(CLK), .RESETN(RESETN),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .ADC_START(st), .ADC_CHAN(ch), .ADC_DONE(dn), .ADC_RESULT(rs),
    .ADC_FAULT(ft), .IRQ(irq));
  scic_adc_model u_adc (.clk(CLK), .start(st), .res(res), .flt(flt), .dly(dly),
    .done(dn), .result(rs), .fault(ft));
  // ****************************************
  // start log and channel-0 period
  // ****************************************
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (st) begin
      chq.push_back(ch);
      if (ch == 2'h0) begin
        per  <= cyc - last;
        last <= cyc;
      end
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    @(posedge CLK);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do begin
      @(posedge CLK);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    r = br;
    bre <= 1'b0;
  endtask : axw
  task automatic axr(input logic [11:0] a);
    @(posedge CLK);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do begin
      @(posedge CLK);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rd;
    r = rr;
    rre <= 1'b0;
  endtask : axr
  // wait for n fresh cycle ends
  task automatic wend(input int n);
    repeat (n) begin
      axw(scic_pkg::REG_STATUS, 32'h00004000);
      do axr(scic_pkg::REG_STATUS); while (d[14] !== 1'b1);
    end
  endtask : wend
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (90000) @(posedge CLK);
    err_count++;
    end_of_test();
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    axr(scic_pkg::REG_CYCLE);
    chk(d, 32'h00000078);
    for (int i = 0; i < 13; i++) begin
      dly <= 8'(i * 20);
      res <= rows[i][33:16];
      axw(scic_pkg::REG_CTRL, 32'(rows[i][45:34]));
      wend(2);
      axr(scic_pkg::REG_VALUE_BASE);
      chk(32'(d[15:0]), 32'(rows[i][15:0]));
    end
    dly <= 8'h05;
    res <= 18'h21C00;
    axw(scic_pkg::REG_CTRL, 32'h00000005);
    wend(2);
    chq.delete();
    wend(1);
    chk(32'(chq.size()), 32'h00000002);
    chk(32'(chq[0]), 32'h00000000);
    chk(32'(chq[1]), 32'h00000002);
    chk(per, 701);
    axw(scic_pkg::REG_CTRL, 32'h0000001F);
    wend(2);
    chk(per, 1081);
    axr(scic_pkg::REG_CYCLE);
    chk(d, 32'h0000006C);
    axw(scic_pkg::REG_CTRL, 32'h00000001);
    axw(scic_pkg::REG_MASK, 32'h00000100);
    flt <= 1'b1;
    wend(2);
    axr(scic_pkg::REG_VALUE_BASE);
    chk(32'(d[18:0]), 32'h00040000);
    chk(32'(irq), 32'h00000001);
    axw(scic_pkg::REG_MASK, 32'h00000000);
    repeat (2) @(posedge CLK);
    chk(32'(irq), 32'h00000000);
    flt <= 1'b0;
    axw(scic_pkg::REG_MASK, 32'h00000100);
    wend(1);
    axw(scic_pkg::REG_STATUS, 32'h00000100);
    repeat (2) @(posedge CLK);
    chk(32'(irq), 32'h00000000);
    axr(12'h0FC);
    chk({r, d[29:0]}, {scic_pkg::RESP_SLVERR, 30'h00000000});
    axw(scic_pkg::REG_CYCLE, 32'h00000001);
    chk(32'(r), 32'(scic_pkg::RESP_SLVERR));
    RESETN <= 1'b0;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    axr(scic_pkg::REG_CTRL);
    chk(d, 32'h0000000F);
    end_of_test();
  end
endmodule : safe_current_input_coder_test
